// ===== lpgc_top.sv
// Gain controller, configuration registers and serial write slave.
// Assumes comparator flags per sink pin, a serial master obeying the bus
// timing, and an enable/reset pin that is low whenever the part is off.
`default_nettype none

module lpgc_top #(
	parameter int unsigned DLY0_US = lpgc_pkg::DLY0_US,
	parameter int unsigned DLY1_US = lpgc_pkg::DLY1_US,
	parameter int unsigned DLY2_US = lpgc_pkg::DLY2_US,
	parameter int unsigned DLY3_US = lpgc_pkg::DLY3_US,
	parameter int unsigned CNT_W = 24
) (
	// Core clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// Enable/reset pin, asynchronous
	input wire logic i_hardware_enable_reset_pin,
	// Serial bus: clock, data in, open-drain data drive
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe,
	// Per-pin low-headroom comparator flags, asynchronous
	input wire logic [lpgc_pkg::SINKS-1:0] i_sink_low,
	// Charge pump and sink controls
	output logic o_gain_boost,
	output logic [lpgc_pkg::SINKS-1:0] o_sink_en,
	output logic o_device_on,
	// Brightness and ramp settings
	output lpgc_pkg::lpgc_levels_t o_levels,
	output logic [7:0] o_ramp_time
);

	// Delay counts in core cycles; exact, so no rounding is needed
	localparam longint unsigned CNT0 = longint'(DLY0_US) * lpgc_pkg::CLK_MHZ;
	localparam longint unsigned CNT1 = longint'(DLY1_US) * lpgc_pkg::CLK_MHZ;
	localparam longint unsigned CNT2 = longint'(DLY2_US) * lpgc_pkg::CLK_MHZ;
	localparam longint unsigned CNT3 = longint'(DLY3_US) * lpgc_pkg::CLK_MHZ;
	localparam longint unsigned CNT_LIM = longint'(1) << CNT_W;

	// Refuse delays the counter cannot hold, or zero delays
	if (CNT_W < 1 || CNT_W > 40 || CNT0 == 0 || CNT1 == 0 || CNT2 == 0 ||
		CNT3 == 0 || CNT0 >= CNT_LIM || CNT1 >= CNT_LIM ||
		CNT2 >= CNT_LIM || CNT3 >= CNT_LIM) begin : g_bad_delay
		$error("lpgc_top: delay counts do not fit the counter");
	end

	// Delay range table, indexed by the delay select field
	localparam logic [CNT_W-1:0] LIMITS [4] = '{
		CNT_W'(CNT0), CNT_W'(CNT1), CNT_W'(CNT2), CNT_W'(CNT3)
	};

	// Which sink pins a general register value switches on
	function automatic logic [lpgc_pkg::SINKS-1:0] sink_mask(
		input logic [lpgc_pkg::GP_W-1:0] gp
	);
		logic [lpgc_pkg::SINKS-1:0] m;
		m = '0;
		m[lpgc_pkg::MAIN_FIXED-1:0] =
			{lpgc_pkg::MAIN_FIXED{gp[lpgc_pkg::GP_EN_MAIN]}};
		// Shared pins follow the group they are assigned to
		m[lpgc_pkg::PIN_D53] = ~gp[lpgc_pkg::GP_SD53] &
			(gp[lpgc_pkg::GP_53A] ? gp[lpgc_pkg::GP_EN_MAIN] :
			gp[lpgc_pkg::GP_EN_SEC]);
		m[lpgc_pkg::PIN_D62] = ~gp[lpgc_pkg::GP_SD62] &
			(gp[lpgc_pkg::GP_62A] ? gp[lpgc_pkg::GP_EN_MAIN] :
			gp[lpgc_pkg::GP_EN_SEC]);
		m[lpgc_pkg::PIN_D1B] = gp[lpgc_pkg::GP_EN_SEC];
		m[lpgc_pkg::PIN_D1C] = gp[lpgc_pkg::GP_EN_IND];
		return m;
	endfunction

	// Synchronisers and core reset (core domain)
	logic hardware_enable_reset_pin_meta, next_hardware_enable_reset_pin_meta; // First stage, read only by the second
	logic hardware_enable_reset_pin_s, next_hardware_enable_reset_pin_s;
	logic [lpgc_pkg::SINKS-1:0] low_meta, next_low_meta;
	logic [lpgc_pkg::SINKS-1:0] low_s, next_low_s;
	logic wtgl_meta, next_wtgl_meta;
	logic wtgl_s, next_wtgl_s;
	logic wtgl_prev, next_wtgl_prev;
	logic core_rst, next_core_rst; // Also clears the link side
	logic wr_evt; // One cycle per serial register write

	// Link side state (serial clock domain)
	logic wr_tgl, next_wr_tgl; // Flips once per completed write
	lpgc_pkg::lpgc_write_t wr_hold, next_wr_hold; // Stable between writes
	logic start_tgl, next_start_tgl; // Flips on each start condition

	// Pin and event synchronisers, next values
	always_comb begin
		next_hardware_enable_reset_pin_meta = i_hardware_enable_reset_pin;
		next_hardware_enable_reset_pin_s = hardware_enable_reset_pin_meta;
		next_low_meta = i_sink_low;
		next_low_s = low_meta;
		next_wtgl_meta = wr_tgl;
		next_wtgl_s = wtgl_meta;
		next_wtgl_prev = wtgl_s;
		// Pin low holds everything at defaults, no bus access needed
		next_core_rst = i_rst | ~hardware_enable_reset_pin_s;
	end

	// Pin and event synchronisers, registers
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			hardware_enable_reset_pin_meta <= 1'b0;
			hardware_enable_reset_pin_s <= 1'b0;
			low_meta <= '0;
			low_s <= '0;
			wtgl_meta <= 1'b0;
			wtgl_s <= 1'b0;
			wtgl_prev <= 1'b0;
			core_rst <= 1'b1;
		end else begin
			hardware_enable_reset_pin_meta <= next_hardware_enable_reset_pin_meta;
			hardware_enable_reset_pin_s <= next_hardware_enable_reset_pin_s;
			low_meta <= next_low_meta;
			low_s <= next_low_s;
			wtgl_meta <= next_wtgl_meta;
			wtgl_s <= next_wtgl_s;
			wtgl_prev <= next_wtgl_prev;
			core_rst <= next_core_rst;
		end
	end

	// A toggle edge marks a finished write; wr_hold is quiet by then
	assign wr_evt = wtgl_s ^ wtgl_prev;

	// Configuration registers
	logic [lpgc_pkg::GP_W-1:0] gp, next_gp; // Bit 7 is not stored
	lpgc_pkg::lpgc_levels_t lvl, next_lvl;
	logic [7:0] ramp, next_ramp; // Passed on to the ramp logic
	logic [lpgc_pkg::DLY_W-1:0] dly, next_dly;
	logic [lpgc_pkg::SINKS-1:0] sink_en, next_sink_en;
	logic dev_on, next_dev_on;

	// Register writes decoded by select code; unknown codes are dropped
	always_comb begin
		next_gp = gp;
		next_lvl = lvl;
		next_ramp = ramp;
		next_dly = dly;
		if (wr_evt) begin
			case (wr_hold.sel)
				lpgc_pkg::REG_GP:
					next_gp = wr_hold.data[lpgc_pkg::GP_W-1:0];
				lpgc_pkg::REG_MAIN:
					next_lvl.main = wr_hold.data[lpgc_pkg::MAIN_W-1:0];
				lpgc_pkg::REG_SEC:
					next_lvl.sec = wr_hold.data[lpgc_pkg::SEC_W-1:0];
				lpgc_pkg::REG_IND:
					next_lvl.ind = wr_hold.data[lpgc_pkg::IND_W-1:0];
				lpgc_pkg::REG_RAMP:
					next_ramp = wr_hold.data;
				lpgc_pkg::REG_DELAY:
					next_dly = wr_hold.data[lpgc_pkg::DLY_W-1:0];
				default: begin
					// Unmapped select: write is acknowledged and ignored
				end
			endcase
		end
		next_sink_en = sink_mask(next_gp);
		next_dev_on = |next_gp[lpgc_pkg::GP_EN_IND:lpgc_pkg::GP_EN_MAIN];
	end

	// Registers return to defaults while the core is held in reset
	always_ff @(posedge i_clock) begin
		if (core_rst) begin
			gp <= lpgc_pkg::RST_GP[lpgc_pkg::GP_W-1:0];
			lvl.main <= lpgc_pkg::RST_MAIN[lpgc_pkg::MAIN_W-1:0];
			lvl.sec <= lpgc_pkg::RST_SEC[lpgc_pkg::SEC_W-1:0];
			lvl.ind <= lpgc_pkg::RST_IND[lpgc_pkg::IND_W-1:0];
			ramp <= lpgc_pkg::RST_RAMP;
			dly <= lpgc_pkg::RST_DELAY[lpgc_pkg::DLY_W-1:0];
			sink_en <= '0;
			dev_on <= 1'b0;
		end else begin
			gp <= next_gp;
			lvl <= next_lvl;
			ramp <= next_ramp;
			dly <= next_dly;
			sink_en <= next_sink_en;
			dev_on <= next_dev_on;
		end
	end

	// Gain controller
	lpgc_pkg::lpgc_gain_state_t gstate, next_gstate;
	logic [CNT_W-1:0] cnt, next_cnt; // Cycles the low condition has held
	logic boost, next_boost;
	logic any_low; // Some enabled sink is short of headroom
	logic [CNT_W-1:0] limit;

	// Only enabled pins count; one low pin is enough to need boost
	assign any_low = |(low_s & sink_mask(gp));
	assign limit = LIMITS[dly];

	// Gain decision with dip filter
	always_comb begin
		next_gstate = gstate;
		next_cnt = cnt;
		case (gstate)
			lpgc_pkg::GS_PASS: begin
				next_cnt = '0;
				if (any_low) begin
					next_gstate = lpgc_pkg::GS_WAIT;
				end
			end
			lpgc_pkg::GS_WAIT: begin
				if (!any_low) begin
					// Short dip: forget it and start over
					next_gstate = lpgc_pkg::GS_PASS;
					next_cnt = '0;
				end else if (cnt >= limit - 1'b1) begin
					next_gstate = lpgc_pkg::GS_BOOST;
					next_cnt = '0;
				end else begin
					next_cnt = cnt + 1'b1;
				end
			end
			lpgc_pkg::GS_BOOST: begin
				// Sticks even when headroom returns, avoiding gain chatter
				next_cnt = '0;
			end
			default: begin
				next_gstate = lpgc_pkg::GS_PASS;
				next_cnt = '0;
			end
		endcase
		// Any register write forces a fresh evaluation from pass gain
		if (wr_evt) begin
			next_gstate = lpgc_pkg::GS_PASS;
			next_cnt = '0;
		end
		next_boost = (next_gstate == lpgc_pkg::GS_BOOST);
	end

	// Gain controller registers
	always_ff @(posedge i_clock) begin
		if (core_rst) begin
			gstate <= lpgc_pkg::GS_PASS;
			cnt <= '0;
			boost <= 1'b0;
		end else begin
			gstate <= next_gstate;
			cnt <= next_cnt;
			boost <= next_boost;
		end
	end

	// Start catcher: data falling while clock high. Clocked by the data
	// line itself because no clock edge separates a stop from a start.
	always_comb begin
		next_start_tgl = i_scl ? ~start_tgl : start_tgl;
	end

	// Start catcher register; link clocks stand still during reset
	always_ff @(negedge i_sda or posedge core_rst) begin
		if (core_rst) begin
			start_tgl <= 1'b0;
		end else begin
			start_tgl <= next_start_tgl;
		end
	end

	// Receive side, on rising serial clock edges
	logic start_seen, next_start_seen;
	logic frame_on, next_frame_on; // Frame addressed to us, still open
	logic [3:0] bit_cnt, next_bit_cnt; // 0..7 data bits, 8 is ack slot
	logic [7:0] shreg, next_shreg;
	logic [7:0] byte_in;
	lpgc_pkg::lpgc_byte_t byte_st, next_byte_st;
	logic ack_due, next_ack_due;
	logic new_frame;

	// start_tgl settles a bus setup time before the first rising edge
	assign new_frame = start_tgl ^ start_seen;
	assign byte_in = {shreg[6:0], i_sda};

	// Frame parser: address, register select, then one data byte
	always_comb begin
		next_start_seen = start_seen;
		next_frame_on = frame_on;
		next_bit_cnt = bit_cnt;
		next_shreg = shreg;
		next_byte_st = byte_st;
		next_ack_due = ack_due;
		next_wr_hold = wr_hold;
		next_wr_tgl = wr_tgl;
		if (new_frame) begin
			// Repeated start behaves exactly like a first start
			next_start_seen = start_tgl;
			next_frame_on = 1'b1;
			next_bit_cnt = lpgc_pkg::BIT_FIRST;
			next_shreg = {7'h00, i_sda};
			next_byte_st = lpgc_pkg::BY_ADDR;
			next_ack_due = 1'b0;
		end else if (frame_on) begin
			if (bit_cnt == lpgc_pkg::BIT_ACK) begin
				next_bit_cnt = 4'h0;
			end else begin
				next_shreg = byte_in;
				next_bit_cnt = bit_cnt + 4'h1;
				if (bit_cnt == lpgc_pkg::BIT_LAST) begin
					next_ack_due = 1'b0;
					case (byte_st)
						lpgc_pkg::BY_ADDR: begin
							// Reads and other addresses are left alone
							if (byte_in == {lpgc_pkg::SLAVE_ADDR, 1'b0}) begin
								next_ack_due = 1'b1;
								next_byte_st = lpgc_pkg::BY_REG;
							end else begin
								next_frame_on = 1'b0;
							end
						end
						lpgc_pkg::BY_REG: begin
							next_wr_hold.sel = byte_in;
							next_ack_due = 1'b1;
							next_byte_st = lpgc_pkg::BY_DATA;
						end
						lpgc_pkg::BY_DATA: begin
							next_wr_hold.data = byte_in;
							next_wr_tgl = ~wr_tgl;
							next_ack_due = 1'b1;
							next_byte_st = lpgc_pkg::BY_EXTRA;
						end
						lpgc_pkg::BY_EXTRA: begin
							// Extra bytes are not acknowledged
						end
						default: next_frame_on = 1'b0;
					endcase
				end
			end
		end
	end

	// Receive side registers
	always_ff @(posedge i_scl or posedge core_rst) begin
		if (core_rst) begin
			start_seen <= 1'b0;
			frame_on <= 1'b0;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			byte_st <= lpgc_pkg::BY_ADDR;
			ack_due <= 1'b0;
			wr_hold <= '0;
			wr_tgl <= 1'b0;
		end else begin
			start_seen <= next_start_seen;
			frame_on <= next_frame_on;
			bit_cnt <= next_bit_cnt;
			shreg <= next_shreg;
			byte_st <= next_byte_st;
			ack_due <= next_ack_due;
			wr_hold <= next_wr_hold;
			wr_tgl <= next_wr_tgl;
		end
	end

	// Acknowledge drive, changed only on falling clock edges
	logic sda_oe, next_sda_oe;
	logic sda_out, next_sda_out;

	// Pull data low through the ninth clock of an accepted byte
	always_comb begin
		next_sda_oe = frame_on & ack_due &
			(bit_cnt == lpgc_pkg::BIT_ACK);
		next_sda_out = 1'b0; // Open drain: only ever pulls low
	end

	// Acknowledge registers
	always_ff @(negedge i_scl or posedge core_rst) begin
		if (core_rst) begin
			sda_oe <= 1'b0;
			sda_out <= 1'b0;
		end else begin
			sda_oe <= next_sda_oe;
			sda_out <= next_sda_out;
		end
	end

	// Outputs, each straight from a flip-flop
	assign o_sda_out = sda_out;
	assign o_sda_oe = sda_oe;
	assign o_gain_boost = boost;
	assign o_sink_en = sink_en;
	assign o_device_on = dev_on;
	assign o_levels = lvl;
	assign o_ramp_time = ramp;

endmodule

`default_nettype wire

// ===== lpgc_pkg.sv
// Constants and types for the LED charge-pump gain controller.
// Assumes a single 100 MHz core clock and a serial bus clocked by its master.
`default_nettype none

package lpgc_pkg;

	// Core clock rate, used to turn microseconds into cycles
	localparam int unsigned CLK_MHZ = 100;

	// Seven-bit serial slave address of the device
	localparam logic [6:0] SLAVE_ADDR = 7'h36;

	// Register select codes
	localparam logic [7:0] REG_GP = 8'h10;
	localparam logic [7:0] REG_MAIN = 8'ha0;
	localparam logic [7:0] REG_SEC = 8'hb0;
	localparam logic [7:0] REG_IND = 8'hc0;
	localparam logic [7:0] REG_RAMP = 8'h20;
	localparam logic [7:0] REG_DELAY = 8'h60;

	// Reset values of the registers
	localparam logic [7:0] RST_GP = 8'h00;
	localparam logic [7:0] RST_MAIN = 8'he0;
	localparam logic [7:0] RST_SEC = 8'hf8;
	localparam logic [7:0] RST_IND = 8'hf8;
	localparam logic [7:0] RST_RAMP = 8'hf0;
	localparam logic [7:0] RST_DELAY = 8'hfc;

	// Bit positions in the general purpose register
	localparam int unsigned GP_EN_MAIN = 0;
	localparam int unsigned GP_EN_SEC = 1;
	localparam int unsigned GP_EN_IND = 2;
	localparam int unsigned GP_SD53 = 3;
	localparam int unsigned GP_SD62 = 4;
	localparam int unsigned GP_53A = 5;
	localparam int unsigned GP_62A = 6;
	localparam int unsigned GP_W = 7;

	// Field widths: brightness levels and delay range select
	localparam int unsigned MAIN_W = 5;
	localparam int unsigned SEC_W = 3;
	localparam int unsigned IND_W = 3;
	localparam int unsigned DLY_W = 2;

	// Current-sink pin indices in the monitor vector
	localparam int unsigned SINKS = 8;
	localparam int unsigned MAIN_FIXED = 4;
	localparam int unsigned PIN_D53 = 4;
	localparam int unsigned PIN_D62 = 5;
	localparam int unsigned PIN_D1B = 6;
	localparam int unsigned PIN_D1C = 7;

	// Default gain transition delays per range, in microseconds
	localparam int unsigned DLY0_US = 3000;
	localparam int unsigned DLY1_US = 1000;
	localparam int unsigned DLY2_US = 6000;
	localparam int unsigned DLY3_US = 12000;

	// Serial bit counter marks
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_FIRST = 4'h1;

	// Gain controller states
	typedef enum logic [2:0] {
		GS_PASS = 3'b001,
		GS_WAIT = 3'b010,
		GS_BOOST = 3'b100
	} lpgc_gain_state_t;

	// Position within a serial write frame
	typedef enum logic [3:0] {
		BY_ADDR = 4'b0001,
		BY_REG = 4'b0010,
		BY_DATA = 4'b0100,
		BY_EXTRA = 4'b1000
	} lpgc_byte_t;

	// Brightness levels of the three groups
	typedef struct packed {
		logic [MAIN_W-1:0] main;
		logic [SEC_W-1:0] sec;
		logic [IND_W-1:0] ind;
	} lpgc_levels_t;

	// One register write caught on the serial bus
	typedef struct packed {
		logic [7:0] sel;
		logic [7:0] data;
	} lpgc_write_t;

endpackage

`default_nettype wire

// ===== lpgc_assertions.sv
// Checker for the gain controller: gain timing, pin reset and bus answer.
// Assumes it is bound to the top and sees only that module's ports.
`default_nettype none

module lpgc_checker #(
	parameter int unsigned DLY0_US = 1,
	parameter int unsigned DLY1_US = 1,
	parameter int unsigned DLY2_US = 1,
	parameter int unsigned DLY3_US = 1
) (
	// Clock and resets
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_hardware_enable_reset_pin,
	// Serial bus
	input wire logic i_scl,
	input wire logic o_sda_out,
	input wire logic o_sda_oe,
	// Gain and sink side
	input wire logic [lpgc_pkg::SINKS-1:0] i_sink_low,
	input wire logic o_gain_boost,
	input wire logic [lpgc_pkg::SINKS-1:0] o_sink_en,
	input wire logic o_device_on,
	input wire lpgc_pkg::lpgc_levels_t o_levels,
	input wire logic [7:0] o_ramp_time
);
	timeunit 1ns;
	timeprecision 100ps;

	// Shortest and longest delay, widened for the synchronisers
	localparam int LO01 = DLY0_US < DLY1_US ? DLY0_US : DLY1_US;
	localparam int LO23 = DLY2_US < DLY3_US ? DLY2_US : DLY3_US;
	localparam int HI01 = DLY0_US > DLY1_US ? DLY0_US : DLY1_US;
	localparam int HI23 = DLY2_US > DLY3_US ? DLY2_US : DLY3_US;
	localparam int LO = LO01 < LO23 ? LO01 : LO23;
	localparam int HI = HI01 > HI23 ? HI01 : HI23;
	localparam int LIM_LO = lpgc_pkg::CLK_MHZ * LO - 10;
	localparam int LIM_HI = lpgc_pkg::CLK_MHZ * HI + 10;

	logic [7:0] quiet; // Cycles since bus clock or enable pin was low
	logic [23:0] run; // Cycles an enabled pin has been low on a quiet bus
	logic [7:0] next_quiet;
	logic [23:0] next_run;
	// Drive level at the last bus clock rise; starts released, so the
	// first falling edge of a run has a known value to compare against
	logic oe_at_rise = 1'b0;
	logic next_oe_at_rise;

	// A write restarts the gain logic, so runs count only on a quiet bus
	always_comb begin
		next_quiet = (quiet == 8'hff) ? quiet : quiet + 8'h01;
		next_run = run + 24'h000001;
		if (i_rst || !i_scl || !i_hardware_enable_reset_pin) begin
			next_quiet = 8'h00;
		end
		if (i_rst || !(|(i_sink_low & o_sink_en)) || quiet < 8'h08) begin
			next_run = 24'h000000;
		end
	end

	// Register the helper counts
	always_ff @(posedge i_clock) begin
		quiet <= next_quiet;
		run <= next_run;
	end

	// Core clock is too slow to see every short high phase of the bus
	// clock, so the drive is caught on the bus clock itself
	always_comb begin
		next_oe_at_rise = i_rst ? 1'b0 : o_sda_oe;
	end

	// Register the drive seen at each rising bus clock edge
	always_ff @(posedge i_scl) begin
		oe_at_rise <= next_oe_at_rise;
	end

	// Enable pin held low long enough to pass its synchronisers
	sequence s_pin_low;
		!i_hardware_enable_reset_pin [*6];
	endsequence

	a_boost_cause: assert property (
		@(posedge i_clock) disable iff (i_rst)
		$rose(o_gain_boost) |-> $past(|(i_sink_low & o_sink_en), 3))
		else $error("gain rose without an enabled low pin");
	a_delay_min: assert property (
		@(posedge i_clock) disable iff (i_rst)
		$rose(o_gain_boost) |-> run >= LIM_LO)
		else $error("gain rose before the delay ran out");
	a_delay_max: assert property (
		@(posedge i_clock) disable iff (i_rst)
		run == LIM_HI |-> o_gain_boost)
		else $error("gain still pass after the longest delay");
	a_boost_sticky: assert property (
		@(posedge i_clock) disable iff (i_rst)
		$fell(o_gain_boost) |-> quiet < 8'h10)
		else $error("gain left 3/2 without a bus write");
	a_pin_reset: assert property (
		@(posedge i_clock) disable iff (i_rst)
		s_pin_low |-> !o_gain_boost && o_sink_en == 8'h00 &&
		o_levels == 11'h000 && o_ramp_time == lpgc_pkg::RST_RAMP)
		else $error("enable pin low did not restore defaults");
	a_on_any: assert property (
		@(posedge i_clock) disable iff (i_rst)
		o_device_on == (o_sink_en != 8'h00) &&
		(o_sink_en[3:0] == 4'h0 || o_sink_en[3:0] == 4'hf))
		else $error("sink enables disagree with group enables");
	a_ack_one: assert property (
		@(negedge i_scl) disable iff (i_rst)
		$rose(o_sda_oe) |=> !o_sda_oe)
		else $error("acknowledge not exactly one bus clock");
	a_oe_stable: assert property (
		@(negedge i_scl) disable iff (i_rst)
		o_sda_oe == oe_at_rise)
		else $error("data drive changed while bus clock high");
	a_sda_low: assert property (
		@(posedge i_clock) disable iff (i_rst) o_sda_out == 1'b0)
		else $error("open drain data level not low");
endmodule

`default_nettype wire

// ===== lpgc_master.sv
// Model of the serial master and the enable driver facing the device.
// Assumes the bench calls its tasks; bus clock is 12 ns, idle between frames.
`default_nettype none

module lpgc_master (
	// Core clock, times the enable pin
	input wire logic i_clock,
	// Device pulls the data line low while high
	input wire logic i_sda_oe,
	// Bus wires and enable pin as the device sees them
	output logic o_scl,
	output logic o_sda,
	output logic o_hw_en
);
	timeunit 1ns;
	timeprecision 100ps;

	logic sda_m; // Own data drive, 1 means released

	// Pull-up: the wire is low while either party pulls it
	assign o_sda = sda_m & ~i_sda_oe;

	// Bus idles high and still; the pin stays high outside resets
	initial begin
		o_scl = 1'b1;
		sda_m = 1'b1;
		o_hw_en = 1'b1;
	end

	// One clock, data set mid-low and held over the high phase
	task automatic clk_bit(input logic b, output logic s);
		#3 sda_m = b;
		#3 o_scl = 1'b1;
		s = o_sda;
		#6 o_scl = 1'b0;
	endtask

	// Start, three bytes MSB first each with ack clock, stop
	task automatic write(input logic [7:0] a, input logic [7:0] s,
		input logic [7:0] d, output logic ok);
		logic [23:0] w;
		logic r;
		w = {a, s, d};
		ok = 1'b1;
		#4 sda_m = 1'b0;
		#6 o_scl = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			clk_bit(w[i], r);
			if (i % 8 == 0) begin
				clk_bit(1'b1, r);
				ok = ok & ~r;
			end
		end
		#3 sda_m = 1'b0;
		#3 o_scl = 1'b1;
		#3 sda_m = 1'b1;
		#6;
	endtask

	// Drive the enable pin low for n core cycles
	task automatic pin_low(input int n);
		@(negedge i_clock);
		o_hw_en = 1'b0;
		repeat (n) @(negedge i_clock);
		o_hw_en = 1'b1;
	endtask
endmodule

`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the gain controller top.
// Assumes the master model and the checker; delays shortened to 1..4 us.
`default_nettype none

`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
	n_mismatch++; end end

module tb_top;
	timeunit 1ns;
	timeprecision 100ps;

	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] sink_low = 8'h00;
	logic scl, sda, hw_en, sda_oe, boost, dev_on, ok;
	logic [7:0] sink_en, ramp;
	lpgc_pkg::lpgc_levels_t levels;
	int n_tests = 0;
	int n_mismatch = 0;
	int cyc = 0;
	int lim;
	logic [31:0] r;
	// Rows: general byte, low pins, expected enables, expected gain
	localparam logic [31:0] ROWS [8] = '{32'h01010f01, 32'h01c00f00,
		32'h02407001, 32'h04808001, 32'h0720ff01, 32'h19300f00,
		32'h61103f01, 32'h00ff0000};

	lpgc_top #(.DLY0_US(1), .DLY1_US(2), .DLY2_US(3), .DLY3_US(4)) uut (
		.i_clock(clk), .i_rst(rst), .i_hardware_enable_reset_pin(hw_en),
		.i_scl(scl), .i_sda(sda), .o_sda_out(), .o_sda_oe(sda_oe),
		.i_sink_low(sink_low), .o_gain_boost(boost), .o_sink_en(sink_en),
		.o_device_on(dev_on), .o_levels(levels), .o_ramp_time(ramp));

	lpgc_master u_host (.i_clock(clk), .i_sda_oe(sda_oe), .o_scl(scl),
		.o_sda(sda), .o_hw_en(hw_en));

	// Core clock, 100 MHz
	always #5 clk = ~clk;

	// Cut a hang short; the run needs about 4400 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	// Verdict and end of run
	task automatic end_of_test();
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Register write to this device, then settle on a falling edge
	task automatic host_write(input logic [7:0] s, input logic [7:0] d);
		u_host.write({lpgc_pkg::SLAVE_ADDR, 1'b0}, s, d, ok);
		`CHK(ok, 1'b1)
		repeat (8) @(negedge clk);
	endtask

	// Outputs that reset must restore
	task automatic chk_defaults();
		`CHK(sink_en, 8'h00)
		`CHK(levels, 11'h000)
		`CHK(ramp, lpgc_pkg::RST_RAMP)
		`CHK(boost, 1'b0)
	endtask

	// Main sequence: table rows first, then the awkward cases
	initial begin
		repeat (2) @(negedge clk);
		rst = 1'b0;
		repeat (10) @(negedge clk);
		chk_defaults();
		for (int k = 0; k < 8; k++) begin
			r = ROWS[k];
			sink_low = 8'h00;
			host_write(lpgc_pkg::REG_GP, r[31:24]);
			sink_low = r[23:16];
			repeat (140) @(negedge clk);
			`CHK(sink_en, r[15:8])
			`CHK(dev_on, |r[26:24])
			`CHK(boost, r[0])
		end
		// Each delay range, with a dip just short of it first
		for (int d = 0; d < 4; d++) begin
			lim = (d + 1) * 100;
			sink_low = 8'h00;
			host_write(lpgc_pkg::REG_DELAY, {6'h3f, d[1:0]});
			host_write(lpgc_pkg::REG_GP, 8'h01);
			sink_low = 8'h01;
			repeat (lim - 10) @(negedge clk);
			sink_low = 8'h00;
			repeat (5) @(negedge clk);
			sink_low = 8'h01;
			repeat (lim - 2) @(negedge clk);
			`CHK(boost, 1'b0)
			repeat (8) @(negedge clk);
			`CHK(boost, 1'b1)
		end
		// Boost holds after the dip ends, until a write re-evaluates
		repeat (30) @(negedge clk);
		sink_low = 8'h00;
		repeat (20) @(negedge clk);
		`CHK(boost, 1'b1)
		host_write(lpgc_pkg::REG_GP, 8'h01);
		`CHK(boost, 1'b0)
		// Brightness fields, an unmapped select and the ramp byte
		host_write(lpgc_pkg::REG_MAIN, 8'hff);
		host_write(lpgc_pkg::REG_SEC, 8'hff);
		host_write(lpgc_pkg::REG_IND, 8'hfd);
		host_write(8'h30, 8'h00);
		`CHK(levels, {5'h1f, 3'h7, 3'h5})
		host_write(lpgc_pkg::REG_RAMP, 8'h5a);
		`CHK(ramp, 8'h5a)
		// Wrong address and read direction are refused
		u_host.write(8'h6e, lpgc_pkg::REG_GP, 8'h00, ok);
		`CHK(ok, 1'b0)
		u_host.write(8'h6d, lpgc_pkg::REG_GP, 8'h00, ok);
		`CHK(ok, 1'b0)
		repeat (8) @(negedge clk);
		`CHK(sink_en, 8'h0f)
		// Enable pin reset, then the default delay range is back
		u_host.pin_low(10);
		repeat (12) @(negedge clk);
		chk_defaults();
		host_write(lpgc_pkg::REG_GP, 8'h01);
		sink_low = 8'h01;
		repeat (110) @(negedge clk);
		`CHK(boost, 1'b1)
		end_of_test();
	end
endmodule

bind lpgc_top lpgc_checker #(.DLY0_US(DLY0_US), .DLY1_US(DLY1_US),
	.DLY2_US(DLY2_US), .DLY3_US(DLY3_US)) u_chk (.i_clock(i_clock),
	.i_rst(i_rst), .i_hardware_enable_reset_pin(i_hardware_enable_reset_pin),
	.i_scl(i_scl), .o_sda_out(o_sda_out), .o_sda_oe(o_sda_oe),
	.i_sink_low(i_sink_low), .o_gain_boost(o_gain_boost),
	.o_sink_en(o_sink_en), .o_device_on(o_device_on), .o_levels(o_levels),
	.o_ramp_time(o_ramp_time));

`default_nettype wire
